/* src/svcc_cfg.svh */
// constant definitions for the serial voltage command controller
`ifndef SVCC_CFG_SVH
`define SVCC_CFG_SVH

// ==========================================
// register map (byte addresses)
`define SVCC_ADDR_CTRL     4'h0
`define SVCC_ADDR_STATUS   4'h4
`define SVCC_ADDR_REFS     4'h8
`define SVCC_CTRL_RESET    32'h0000_040c

// ==========================================
// voltage codes
`define SVCC_CODE_OFF      8'hf8
`define SVCC_BOOT_1V1      8'h48
`define SVCC_BOOT_1V0      8'h58
`define SVCC_BOOT_0V9      8'h68
`define SVCC_BOOT_0V8      8'h78

// ==========================================
// command byte fields
`define SVCC_SEL_CORE      7
`define SVCC_SEL_SOC       6
`define SVCC_PSI_BIT       5

// ==========================================
// timing
`define SVCC_CLK_NS        50
`define SVCC_STEP_NS       625
`define SVCC_STEP_CYC      (`SVCC_STEP_NS / `SVCC_CLK_NS)
`define SVCC_REQ_NS        200
`define SVCC_REQ_CYC       (`SVCC_REQ_NS / `SVCC_CLK_NS)
`define SVCC_BITS          4'h8

`endif

/* src/svcc_pkg.sv */
// types shared by the serial voltage command controller
package svcc_pkg;

    // gray coded along off -> start -> run -> fault
    typedef enum logic [1:0] {
        SVCC_OFF   = 2'b00,
        SVCC_START = 2'b01,
        SVCC_RUN   = 2'b11,
        SVCC_FAULT = 2'b10
    } svcc_state_t;

    typedef struct packed {
        logic [7:0] decay_mult;
        logic [7:0] step_div;
    } svcc_ctrl_t;

    typedef struct packed {
        logic       sel_core;
        logic       sel_soc;
        logic       psi;
        logic [7:0] code;
    } svcc_cmd_t;

endpackage

/* src/svcc_top.sv */
// serial voltage command controller for a two rail regulator
// ==========================================
// How it works
// - bus ignored until host power ok; then commands are monitored
// - command byte selects core, soc or both rails
// - turning a rail off keeps core output good high
// - power ok loss steps both references back to the boot code
// - while power ok is low the bus lines are not sampled
// - power ok return resumes waiting for commands
// - enable loss puts gate drive in high impedance, goods low
// - enable loss clears boot code; restart re-samples and latches it
// - power-on reset event shuts rails, goods low, drops boot code
// - fault latches off until enable cycles; boot code not kept
// - each received byte is acknowledged by pulling data low
// - upward move steps reference at the programmed slew rate
// - upward move requests transition complete on arrival
// - downward move without power state bit steps actively
// - downward move with power state bit steps slowly following decay
// - decay case requests transition complete at decode time
// - transition complete waits while telemetry is busy
// - host drives clock and frames; device only pulls data low for acks and transition complete
// - code zero is highest voltage; each increment one step lower
// - enable rise latches clock and data lines as boot code
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`include "svcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module svcc_top #(
    parameter int NRAIL = 2
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // pins from outside
    input  wire logic        i_enable,
    input  wire logic        i_por_event,
    input  wire logic        i_fault,
    input  wire logic        i_host_power_ok,
    input  wire logic        i_serial_vid_clock,
    input  wire logic        i_serial_vid_data,
    input  wire logic        i_telemetry_busy,
    // serial data pin drive (open drain)
    output logic             o_serial_vid_data,
    output logic             o_serial_vid_data_oe,
    // regulator side
    output logic             o_gate_hiz,
    output logic             o_core_output_good,
    output logic             o_soc_output_good,
    output logic [7:0]       o_core_ref,
    output logic [7:0]       o_soc_ref
);

    // ==========================================
    // input synchronisers
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_m;
    logic [NPIN-1:0] pin_s;
    assign pin_raw = {i_enable, i_por_event, i_fault,
                      i_host_power_ok, i_serial_vid_clock, i_serial_vid_data};

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    pin_m[gp] <= 1'b0;
                    pin_s[gp] <= 1'b0;
                end else begin
                    pin_m[gp] <= pin_raw[gp];
                    pin_s[gp] <= pin_m[gp];
                end
            end
        end
    endgenerate

    logic en_s, por_s, flt_s, pok_s, sclk_s, sdat_s;
    assign {en_s, por_s, flt_s, pok_s, sclk_s, sdat_s} = pin_s;

    // ==========================================
    // control register
    svcc_pkg::svcc_ctrl_t ctrl;
    logic                 bus_ack;
    logic                 req;
    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~bus_ack;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl <= svcc_pkg::svcc_ctrl_t'(16'(`SVCC_CTRL_RESET));
        end else if (i_avs_write && bus_ack && i_avs_address == `SVCC_ADDR_CTRL) begin
            // write lands on the edge that completes the transfer
            if (i_avs_byteenable[0]) begin
                ctrl.step_div <= i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
                ctrl.decay_mult <= i_avs_writedata[15:8];
            end
        end
    end

    // ==========================================
    // power state machine
    svcc_pkg::svcc_state_t state;
    logic                  fault_latch;
    logic                  boot_valid;
    logic [7:0]            boot_code;
    logic [7:0]            ref_q [NRAIL];
    logic [7:0]            tgt_q [NRAIL];
    logic [NRAIL-1:0]      at_tgt;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= svcc_pkg::SVCC_OFF;
        end else if (!en_s || por_s) begin
            state <= svcc_pkg::SVCC_OFF;
        end else begin
            unique case (state)
                svcc_pkg::SVCC_OFF: begin
                    if (!fault_latch && !flt_s) begin
                        state <= svcc_pkg::SVCC_START;
                    end
                end
                svcc_pkg::SVCC_START: begin
                    if (flt_s) begin
                        state <= svcc_pkg::SVCC_FAULT;
                    end else if (&at_tgt) begin
                        state <= svcc_pkg::SVCC_RUN;
                    end
                end
                svcc_pkg::SVCC_RUN: begin
                    if (flt_s) begin
                        state <= svcc_pkg::SVCC_FAULT;
                    end
                end
                svcc_pkg::SVCC_FAULT: begin
                    state <= svcc_pkg::SVCC_FAULT;
                end
            endcase
        end
    end

    // fault latch survives until enable drops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fault_latch <= 1'b0;
        end else if (!en_s) begin
            fault_latch <= 1'b0;
        end else if (flt_s && state != svcc_pkg::SVCC_OFF) begin
            fault_latch <= 1'b1;
        end
    end

    // boot code capture on the enable rise
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_valid <= 1'b0;
            boot_code  <= `SVCC_CODE_OFF;
        end else if (!en_s || por_s || state == svcc_pkg::SVCC_FAULT) begin
            boot_valid <= 1'b0;
        end else if (state == svcc_pkg::SVCC_OFF && !boot_valid) begin
            boot_valid <= 1'b1;
            unique case ({sclk_s, sdat_s})
                2'b00: boot_code <= `SVCC_BOOT_1V1;
                2'b01: boot_code <= `SVCC_BOOT_1V0;
                2'b10: boot_code <= `SVCC_BOOT_0V9;
                2'b11: boot_code <= `SVCC_BOOT_0V8;
            endcase
        end
    end

    logic running;
    logic listen;
    assign running = state == svcc_pkg::SVCC_RUN;
    assign listen  = running & pok_s;

    // ==========================================
    // serial receiver, host owns clock and framing
    logic       sclk_d, sdat_d;
    logic       in_frame, byte_idx, ack_drive;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] cmd_byte;
    logic       cmd_stb;
    svcc_pkg::svcc_cmd_t cmd;
    logic sclk_rise, sclk_fall, start_c, stop_c;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_d <= 1'b1;
            sdat_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            sdat_d <= sdat_s;
        end
    end

    assign sclk_rise = listen & sclk_s & ~sclk_d;
    assign sclk_fall = listen & ~sclk_s & sclk_d;
    assign start_c   = listen & sclk_s & sclk_d & sdat_d & ~sdat_s;
    assign stop_c    = listen & sclk_s & sclk_d & ~sdat_d & sdat_s;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_frame  <= 1'b0;
            byte_idx  <= 1'b0;
            ack_drive <= 1'b0;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            cmd_byte  <= 8'h00;
            cmd_stb   <= 1'b0;
        end else begin
            cmd_stb <= 1'b0;
            if (!listen || stop_c) begin
                in_frame  <= 1'b0;
                ack_drive <= 1'b0;
            end else if (start_c) begin
                in_frame <= 1'b1;
                byte_idx <= 1'b0;
                bit_cnt  <= 4'h0;
            end else if (in_frame && sclk_rise && bit_cnt < `SVCC_BITS) begin
                shreg   <= {shreg[6:0], sdat_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (in_frame && sclk_fall && bit_cnt == `SVCC_BITS) begin
                if (!ack_drive) begin
                    ack_drive <= 1'b1;
                    if (!byte_idx) begin
                        cmd_byte <= shreg;
                    end else begin
                        cmd_stb <= 1'b1;
                    end
                end else begin
                    ack_drive <= 1'b0;
                    bit_cnt   <= 4'h0;
                    byte_idx  <= ~byte_idx;
                end
            end
        end
    end

    assign cmd.sel_core = cmd_byte[`SVCC_SEL_CORE];
    assign cmd.sel_soc  = cmd_byte[`SVCC_SEL_SOC];
    assign cmd.psi      = cmd_byte[`SVCC_PSI_BIT];
    assign cmd.code     = shreg;

    // ==========================================
    // step rate dividers
    logic [7:0] step_cnt;
    logic [7:0] decay_cnt;
    logic       step_en, decay_en;
    assign step_en  = step_cnt == 8'h00;
    assign decay_en = step_en && decay_cnt == 8'h00;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            step_cnt  <= 8'h00;
            decay_cnt <= 8'h00;
        end else if (step_en) begin
            step_cnt  <= ctrl.step_div;
            decay_cnt <= decay_en ? ctrl.decay_mult : decay_cnt - 8'h01;
        end else begin
            step_cnt <= step_cnt - 8'h01;
        end
    end

    // ==========================================
    // per rail reference stepping
    logic [NRAIL-1:0] sel;
    logic [NRAIL-1:0] slow;
    logic [NRAIL-1:0] tc_set;
    assign sel = {cmd.sel_soc, cmd.sel_core};

    genvar gr;
    generate
        for (gr = 0; gr < NRAIL; gr++) begin : g_rail
            logic [7:0] aim;
            logic       stp;
            assign aim    = running ? tgt_q[gr] : boot_code;
            assign at_tgt[gr] = ref_q[gr] == aim;
            assign stp    = slow[gr] ? decay_en : step_en;

            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    tgt_q[gr] <= `SVCC_CODE_OFF;
                    slow[gr]  <= 1'b0;
                end else if (!running || !pok_s) begin
                    tgt_q[gr] <= boot_code;
                    slow[gr]  <= 1'b0;
                end else if (cmd_stb && sel[gr]) begin
                    tgt_q[gr] <= cmd.code;
                    slow[gr]  <= cmd.psi && cmd.code > ref_q[gr];
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    ref_q[gr] <= `SVCC_CODE_OFF;
                end else if (state == svcc_pkg::SVCC_OFF || state == svcc_pkg::SVCC_FAULT) begin
                    ref_q[gr] <= `SVCC_CODE_OFF;
                end else if (stp && ref_q[gr] > aim) begin
                    ref_q[gr] <= ref_q[gr] - 8'h01;
                end else if (stp && ref_q[gr] < aim) begin
                    ref_q[gr] <= ref_q[gr] + 8'h01;
                end
            end

            // request on arrival, or at decode for the decay path
            logic moving;
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    moving <= 1'b0;
                end else if (!listen) begin
                    moving <= 1'b0;
                end else if (cmd_stb && sel[gr]) begin
                    moving <= !(cmd.psi && cmd.code > ref_q[gr]);
                end else if (at_tgt[gr]) begin
                    moving <= 1'b0;
                end
            end
            assign tc_set[gr] = listen && ((moving && at_tgt[gr])
                                || (cmd_stb && sel[gr] && cmd.psi
                                    && cmd.code > ref_q[gr]));
        end
    endgenerate

    // ==========================================
    // transition complete request
    logic       tc_pend;
    logic [3:0] tc_cnt;
    logic       tc_drive;
    logic       tc_done;
    assign tc_done = tc_drive && tc_cnt == 4'h0;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tc_pend <= 1'b0;
        end else if (!listen) begin
            tc_pend <= 1'b0;
        end else begin
            tc_pend <= (|tc_set) | (tc_pend & ~tc_done); // set wins
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tc_drive <= 1'b0;
            tc_cnt   <= 4'h0;
        end else if (!listen || in_frame) begin
            tc_drive <= 1'b0;
        end else if (tc_drive) begin
            tc_drive <= tc_cnt != 4'h0;
            tc_cnt   <= tc_cnt - 4'h1;
        end else if (tc_pend && !i_telemetry_busy) begin
            tc_drive <= 1'b1;
            tc_cnt   <= 4'(`SVCC_REQ_CYC - 1);
        end
    end

    assign o_serial_vid_data    = 1'b0;
    assign o_serial_vid_data_oe = ack_drive | tc_drive;

    // ==========================================
    // outputs
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_gate_hiz         <= 1'b1;
            o_core_output_good <= 1'b0;
            o_soc_output_good  <= 1'b0;
        end else begin
            o_gate_hiz         <= !running && state != svcc_pkg::SVCC_START;
            // rail-off codes do not drop the goods
            o_core_output_good <= running;
            o_soc_output_good  <= running;
        end
    end

    assign o_core_ref = ref_q[0];
    assign o_soc_ref  = ref_q[1];

    // ==========================================
    // register read port
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_ack        <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            bus_ack <= req & ~bus_ack;
            if (i_avs_read && !bus_ack) begin
                unique case (i_avs_address)
                    `SVCC_ADDR_CTRL:   o_avs_readdata <= {16'h0, ctrl};
                    `SVCC_ADDR_STATUS: o_avs_readdata <= {24'h0, tc_pend, in_frame,
                        boot_valid, fault_latch, pok_s, running, state};
                    `SVCC_ADDR_REFS:   o_avs_readdata <= {tgt_q[1], tgt_q[0],
                        ref_q[1], ref_q[0]};
                    default:           o_avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ==========================================
    // checks
    sequence s_enable_lost;
        !en_s;
    endsequence
    sequence s_goods_low;
        !o_core_output_good && !o_soc_output_good;
    endsequence

    AST_ENABLE_LOSS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_enable_lost |-> ##2 (s_goods_low and o_gate_hiz))
        else $error("enable loss did not drop goods");
    AST_POR_BOOT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        por_s |=> !boot_valid ##1 s_goods_low)
        else $error("por did not clear boot code");
    AST_NO_LISTEN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !pok_s |=> !in_frame && !cmd_stb)
        else $error("bus used without power ok");
    AST_BOOT_TARGET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        running && !pok_s |=> tgt_q[0] == boot_code && tgt_q[1] == boot_code)
        else $error("targets not returned to boot code");
    AST_BOOT_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        boot_valid && $past(boot_valid) && running |-> $stable(boot_code))
        else $error("boot code resampled");
    AST_ACK_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ack_drive && listen && !sclk_fall && !stop_c |=> ack_drive)
        else $error("ack released early");
    AST_FAULT_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        fault_latch && en_s |=> state != svcc_pkg::SVCC_RUN)
        else $error("restart while fault latched");
    AST_TC_TELEM: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(tc_drive) |-> !$past(i_telemetry_busy))
        else $error("request sent over telemetry");
    AST_TC_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(tc_drive) && !in_frame && !i_telemetry_busy |-> tc_drive [*4])
        else $error("request pulse too short");
    AST_STEP_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        running |=> (ref_q[0] == $past(ref_q[0]) || ref_q[0] == $past(ref_q[0]) + 8'h01
            || ref_q[0] == $past(ref_q[0]) - 8'h01) || !running)
        else $error("reference jumped");

endmodule

`default_nettype wire

/* bench/svcc_host_model.sv */
// host side model that masters the serial voltage link
`timescale 1ns/1ns
`default_nettype none

module svcc_host_model (
    // system clock paces the host
    input  wire logic i_clk,
    // resolved data wire and device pull-down
    input  wire logic i_line,
    input  wire logic i_line_oe,
    // lines the host drives
    output logic      o_clock,
    output logic      o_data_drv
);
    int   acks = 0;
    int   tc_reqs = 0;
    logic in_frame = 1'b0;
    logic oe_q = 1'b0;

    initial begin
        o_clock = 1'b1;
        o_data_drv = 1'b1;
    end

    // device pull-downs outside a frame are transition-complete requests
    always @(posedge i_clk) begin
        oe_q <= i_line_oe;
        if (!in_frame && i_line_oe && !oe_q) begin
            tc_reqs <= tc_reqs + 1;
        end
    end

    task automatic dly(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic set_lines(input logic c, input logic d);
        o_clock <= c;
        o_data_drv <= d;
    endtask

    // one bit is 8 system cycles, a 400 ns link period
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_clock <= 1'b0;
            dly(2);
            o_data_drv <= b[i];
            dly(2);
            o_clock <= 1'b1;
            dly(4);
        end
        o_clock <= 1'b0;
        o_data_drv <= 1'b1;
        dly(4);
        o_clock <= 1'b1;
        dly(2);
        if (i_line === 1'b0) begin
            acks++;
        end
        dly(2);
    endtask

    // host opens and closes every frame; clock rests high between frames
    task automatic send_cmd(input logic [7:0] b0, input logic [7:0] b1);
        in_frame = 1'b1;
        o_data_drv <= 1'b0;
        dly(4);
        send_byte(b0);
        send_byte(b1);
        o_clock <= 1'b0;
        dly(2);
        o_data_drv <= 1'b0;
        dly(2);
        o_clock <= 1'b1;
        dly(2);
        o_data_drv <= 1'b1;
        dly(4);
        in_frame = 1'b0;
    endtask
endmodule

`default_nettype wire

/* bench/svcc_top_bench.sv */
// self-checking bench for the serial voltage command controller
`timescale 1ns/1ns
`default_nettype none

module svcc_top_bench;
    logic i_clk, i_rst_b, rd, wr, en, por, flt, pok, tbusy, sclk, sdrv, oe, hiz, cg, sg, odat;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, got;
    logic        wreq;
    logic [7:0]  cref, sref;
    wire         sline = sdrv & ~oe;
    int          errors = 0;
    int          checked = 0;
    int          cyc = 0;
    int          t0;

    svcc_top u_svcc_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_enable(en), .i_por_event(por),
        .i_fault(flt), .i_host_power_ok(pok), .i_serial_vid_clock(sclk),
        .i_serial_vid_data(sline), .i_telemetry_busy(tbusy), .o_serial_vid_data(odat),
        .o_serial_vid_data_oe(oe), .o_gate_hiz(hiz), .o_core_output_good(cg),
        .o_soc_output_good(sg), .o_core_ref(cref), .o_soc_ref(sref));

    svcc_host_model u_svcc_host_model (.i_clk(i_clk), .i_line(sline), .i_line_oe(oe),
        .o_clock(sclk), .o_data_drv(sdrv));

    // ==========================================
    // clock, timeout and checking
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until a rising edge sees waitrequest low; data taken there
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wait_refs(input logic [7:0] c, input logic [7:0] s);
        for (int n = 0; n < 4000 && (cref !== c || sref !== s); n++) @(posedge i_clk);
        chk("core_ref", {24'h0, cref}, {24'h0, c});
        chk("soc_ref", {24'h0, sref}, {24'h0, s});
    endtask

    task automatic chk_pins(input logic h, input logic g);
        chk("gate_hiz", {31'h0, hiz}, {31'h0, h});
        chk("goods", {30'h0, cg, sg}, {30'h0, g, g});
        chk("data_drive", {31'h0, odat}, 32'h0);
    endtask

    // ==========================================
    // test sequence
    initial begin
        {i_rst_b, rd, wr, en, por, flt, pok, tbusy} = '0;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        av(1'b0, 4'h0, 32'h0);
        chk("ctrl_reset", got, 32'h0000_040c);
        av(1'b1, 4'h0, 32'h0000_0401);
        av(1'b1, 4'hc, 32'hffff_ffff);
        av(1'b0, 4'hc, 32'h0);
        chk("unmapped", got, 32'h0);
        av(1'b0, 4'h0, 32'h0);
        chk("ctrl", got, 32'h0000_0401);
        u_svcc_host_model.set_lines(1'b1, 1'b0);
        en <= 1'b1;
        wait_refs(8'h68, 8'h68);
        repeat (10) @(posedge i_clk);
        chk_pins(1'b0, 1'b1);
        u_svcc_host_model.send_cmd(8'h80, 8'h60);
        chk("acks_early", u_svcc_host_model.acks, 0);
        pok <= 1'b1;
        repeat (10) @(posedge i_clk);
        u_svcc_host_model.send_cmd(8'h80, 8'h60);
        chk("acks", u_svcc_host_model.acks, 2);
        wait_refs(8'h60, 8'h68);
        repeat (20) @(posedge i_clk);
        chk("tc_up", u_svcc_host_model.tc_reqs, 1);
        u_svcc_host_model.send_cmd(8'he0, 8'h70);
        repeat (10) @(posedge i_clk);
        chk("tc_decay", u_svcc_host_model.tc_reqs, 2);
        chk("decay_slow", {31'h0, cref === 8'h70}, 32'h0);
        wait_refs(8'h70, 8'h70);
        tbusy <= 1'b1;
        u_svcc_host_model.send_cmd(8'hc0, 8'h78);
        wait_refs(8'h78, 8'h78);
        repeat (20) @(posedge i_clk);
        chk("tc_held", u_svcc_host_model.tc_reqs, 2);
        tbusy <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk("tc_down", u_svcc_host_model.tc_reqs, 3);
        u_svcc_host_model.send_cmd(8'h80, 8'hf8);
        wait_refs(8'hf8, 8'h78);
        chk_pins(1'b0, 1'b1);
        pok <= 1'b0;
        wait_refs(8'h68, 8'h68);
        t0 = u_svcc_host_model.acks;
        u_svcc_host_model.send_cmd(8'h40, 8'h50);
        chk("acks_pok_low", u_svcc_host_model.acks, t0);
        pok <= 1'b1;
        repeat (10) @(posedge i_clk);
        u_svcc_host_model.send_cmd(8'h40, 8'h50);
        wait_refs(8'h68, 8'h50);
        en <= 1'b0;
        pok <= 1'b0;
        repeat (5) @(posedge i_clk);
        chk_pins(1'b1, 1'b0);
        u_svcc_host_model.set_lines(1'b0, 1'b1);
        en <= 1'b1;
        wait_refs(8'h58, 8'h58);
        flt <= 1'b1;
        repeat (5) @(posedge i_clk);
        flt <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk_pins(1'b1, 1'b0);
        en <= 1'b0;
        u_svcc_host_model.set_lines(1'b0, 1'b0);
        repeat (5) @(posedge i_clk);
        en <= 1'b1;
        wait_refs(8'h48, 8'h48);
        por <= 1'b1;
        repeat (5) @(posedge i_clk);
        chk_pins(1'b1, 1'b0);
        u_svcc_host_model.set_lines(1'b1, 1'b1);
        por <= 1'b0;
        wait_refs(8'h78, 8'h78);
        av(1'b0, 4'h8, 32'h0);
        chk("refs", got, 32'h7878_7878);
        av(1'b0, 4'h4, 32'h0);
        chk("status", got, 32'h0000_0027);
        tally_and_finish();
    end
endmodule

`default_nettype wire
